/* File: pss_pkg.sv */
package pss_pkg;
  // Resource indices
  localparam int NRES = 6;
  localparam int RES_BUCK = 0;
  localparam int RES_CLIN = 1;
  localparam int RES_LNLIN = 2;
  localparam int RES_RADIO = 3;
  localparam int RES_PLL = 4;
  localparam int RES_CORE = 5;
  localparam int TW = 8;
  localparam int WW = 16;
  localparam int SW = 32;
  localparam int IW = 3;
  // Each bit names a resource that must be on first
  localparam logic [5:0] DEP_BUCK = 6'h00;
  localparam logic [5:0] DEP_CLIN = 6'h01;
  localparam logic [5:0] DEP_LNLIN = 6'h01;
  localparam logic [5:0] DEP_RADIO = 6'h04;
  localparam logic [5:0] DEP_PLL = 6'h02;
  localparam logic [5:0] DEP_CORE = 6'h01;
  // Reset values of the timing table, in low-power ticks
  localparam logic [7:0] TON_RST = 8'h02;
  localparam logic [7:0] TOFF_RST = 8'h01;
  localparam logic [7:0] TIMER_ZERO = 8'h00;
  localparam logic [7:0] TIMER_ONE = 8'h01;
  localparam logic [15:0] WAKE_ZERO = 16'h0000;
  localparam logic [15:0] WAKE_ONE = 16'h0001;
  localparam logic [31:0] STATE_RST = 32'h0000_0000;
  // Wireless power modes
  typedef enum logic [2:0] {
    PSS_ACTIVE, PSS_DOZE, PSS_SAVE, PSS_DEEP, PSS_RESTORE, PSS_OFF
  } pss_mode_t;

  function automatic logic [5:0] dep_mask(input int idx);
    case (idx)
      RES_BUCK: dep_mask = DEP_BUCK;
      RES_CLIN: dep_mask = DEP_CLIN;
      RES_LNLIN: dep_mask = DEP_LNLIN;
      RES_RADIO: dep_mask = DEP_RADIO;
      RES_PLL: dep_mask = DEP_PLL;
      default: dep_mask = DEP_CORE;
    endcase
  endfunction : dep_mask
endpackage : pss_pkg

/* File: pss_res_if.sv */
interface pss_res_if;
  logic tick;
  logic request;
  logic deps_ok;
  logic no_dependents;
  logic [7:0] time_on;
  logic [7:0] time_off;
  logic resource_on_state;
  logic resource_transition_pending;
  modport slot (
    input tick, request, deps_ok, no_dependents, time_on, time_off,
    output resource_on_state, resource_transition_pending
  );
  modport ctrl (
    output tick, request, deps_ok, no_dependents, time_on, time_off,
    input resource_on_state, resource_transition_pending
  );
endinterface : pss_res_if

/* File: pss_res_slot.sv */
module pss_res_slot (
  input wire logic ref_clk,
  input wire logic reset,
  pss_res_if.slot res
);
  logic on_ff;
  logic pend_ff;
  logic [7:0] timer_ff;

  assign res.resource_on_state = on_ff;
  assign res.resource_transition_pending = pend_ff;

  // Timer only moves on low-power ticks, so all transitions are LOW_POWER_OSCILLATOR-timed
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      on_ff <= 1'b0;
      pend_ff <= 1'b0;
      timer_ff <= pss_pkg::TIMER_ZERO;
    end else if (res.tick) begin
      if (pend_ff) begin
        timer_ff <= timer_ff - pss_pkg::TIMER_ONE;
        if (timer_ff == pss_pkg::TIMER_ONE) begin
          pend_ff <= 1'b0;
          on_ff <= ~on_ff;
        end
      end else if (on_ff && !res.request && res.no_dependents) begin
        if (res.time_off == pss_pkg::TIMER_ZERO) begin
          on_ff <= 1'b0;
        end else begin
          timer_ff <= res.time_off;
          pend_ff <= 1'b1;
        end
      end else if (!on_ff && res.request && res.deps_ok) begin
        if (res.time_on == pss_pkg::TIMER_ZERO) begin
          on_ff <= 1'b1;
        end else begin
          timer_ff <= res.time_on;
          pend_ff <= 1'b1;
        end
      end
    end
  end

  AST_PEND_TIMER_NONZERO: assert property (
    @(posedge ref_clk) disable iff (reset)
    pend_ff |-> timer_ff != pss_pkg::TIMER_ZERO)
    else $error("pending resource with idle timer");

  AST_EXPIRY_FLIPS: assert property (
    @(posedge ref_clk) disable iff (reset)
    (res.tick && pend_ff && timer_ff == pss_pkg::TIMER_ONE)
      |=> (!pend_ff && on_ff != $past(on_ff)))
    else $error("expired timer did not flip state");

  AST_NO_MOVE_WITHOUT_TICK: assert property (
    @(posedge ref_clk) disable iff (reset)
    !res.tick |=> $stable(timer_ff) && $stable(on_ff))
    else $error("resource moved without a low-power tick");

  AST_ON_NEEDS_DEPS: assert property (
    @(posedge ref_clk) disable iff (reset)
    (res.tick && !on_ff && !pend_ff && res.request && !res.deps_ok)
      |=> !on_ff && !pend_ff)
    else $error("enable started before dependencies were on");
endmodule : pss_res_slot

/* File: pss_sequencer.sv */
// Summary of operation
// - Either host section enable powers regulators and releases its section.
// - Buck, core linear and low-noise linear regulators on when either enable.
// - Buck regulator shuts down only when both section enables are low.
// - Linear regulators follow digital baseband demand dynamically.
// - Resources switch from computed demand and programmable on/off times.
// - Transitions are timed by counters on the low-power oscillator.
// - Active mode powers radio, PLL and core while wireless is enabled, and gates clocks when unneeded.
// - Doze stops PLL and reference clocks, powers down radio and analog.
// - During doze only the sequencer runs, to wake the chip.
// - Core state is saved to retention memory before deep sleep.
// - Deep sleep ends on timer expiry, external interrupt or USB resume.
// - Waking from deep sleep restores retained state, no full reset.
// - Power-down has buck and both linear regulators off until external re-enable.
// - Lowest-power state shuts the three regulators; always-on one supplies.
// - Resource timer loads on transition, decrements each low-power tick.
// - Timer reaching zero clears pending and flips state; zero is instant.
// - Disable unrequested resources without dependents; enable when deps on.
// - Wireless section held in reset while its enable is low.
module pss_sequencer (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic wireless_section_enable,
  input wire logic short_range_section_enable,
  input wire logic low_power_oscillator,
  input wire logic ext_wake_irq,
  input wire logic usb_resume,
  input wire logic baseband_demand,
  input wire logic clock_needed,
  input wire logic doze_request,
  input wire logic deep_sleep_request,
  input wire logic [15:0] wake_ticks,
  input wire logic [31:0] core_state_in,
  input wire logic prog_we,
  input wire logic [2:0] prog_index,
  input wire logic [7:0] prog_time_on,
  input wire logic [7:0] prog_time_off,
  output logic core_buck_regulator_en,
  output logic core_linear_regulator_en,
  output logic low_noise_linear_regulator_en,
  output logic always_on_low_power_regulator_en,
  output logic radio_power_en,
  output logic ref_clock_en,
  output logic core_power_en,
  output logic core_clock_en,
  output logic wireless_section_in_reset,
  output logic short_range_section_in_reset,
  output logic retention_save,
  output logic retention_restore,
  output logic [31:0] core_state_out,
  output logic [2:0] power_mode
);
  localparam int N = pss_pkg::NRES;

  logic [1:0] wl_sync_ff;
  logic [1:0] sr_sync_ff;
  logic [1:0] lpo_sync_ff;
  logic lpo_last_ff;
  logic [1:0] irq_sync_ff;
  logic [1:0] usb_sync_ff;
  logic lpo_tick;
  logic wl_on;
  logic any_on;
  logic wake_event;
  logic [N-1:0] demand;
  logic [N-1:0] on_vec;
  logic [N-1:0] pend_vec;
  logic [7:0] time_on_ff [N];
  logic [7:0] time_off_ff [N];
  logic [15:0] wake_cnt_ff;
  logic [31:0] retain_ff;
  pss_pkg::pss_mode_t mode_ff;
  pss_pkg::pss_mode_t nxt_mode;

  // Enable, oscillator and wake pins cross into ref_clk through two flops before any use
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wl_sync_ff <= 2'h0;
      sr_sync_ff <= 2'h0;
      lpo_sync_ff <= 2'h0;
      lpo_last_ff <= 1'b0;
      irq_sync_ff <= 2'h0;
      usb_sync_ff <= 2'h0;
    end else begin
      wl_sync_ff <= {wl_sync_ff[0], wireless_section_enable};
      sr_sync_ff <= {sr_sync_ff[0], short_range_section_enable};
      lpo_sync_ff <= {lpo_sync_ff[0], low_power_oscillator};
      lpo_last_ff <= lpo_sync_ff[1];
      irq_sync_ff <= {irq_sync_ff[0], ext_wake_irq};
      usb_sync_ff <= {usb_sync_ff[0], usb_resume};
    end
  end

  assign lpo_tick = lpo_sync_ff[1] & ~lpo_last_ff;
  assign wl_on = wl_sync_ff[1];
  assign any_on = wl_sync_ff[1] | sr_sync_ff[1];
  assign wake_event = irq_sync_ff[1] | usb_sync_ff[1] |
    (wake_cnt_ff == pss_pkg::WAKE_ZERO);

  // Programmable turn-on and turn-off table
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < N; i++) begin
        time_on_ff[i] <= pss_pkg::TON_RST;
        time_off_ff[i] <= pss_pkg::TOFF_RST;
      end
    end else if (prog_we && prog_index < 3'(N)) begin
      time_on_ff[prog_index] <= prog_time_on;
      time_off_ff[prog_index] <= prog_time_off;
    end
  end

  // Power mode sequencing; power-down whenever both enables drop
  always_comb begin
    nxt_mode = mode_ff;
    case (mode_ff)
      pss_pkg::PSS_ACTIVE: begin
        if (!any_on) nxt_mode = pss_pkg::PSS_OFF;
        else if (deep_sleep_request) nxt_mode = pss_pkg::PSS_SAVE;
        else if (doze_request) nxt_mode = pss_pkg::PSS_DOZE;
      end
      pss_pkg::PSS_DOZE: begin
        if (!any_on) nxt_mode = pss_pkg::PSS_OFF;
        else if (wake_event) nxt_mode = pss_pkg::PSS_ACTIVE;
      end
      pss_pkg::PSS_SAVE: nxt_mode = pss_pkg::PSS_DEEP;
      pss_pkg::PSS_DEEP: begin
        if (!any_on) nxt_mode = pss_pkg::PSS_OFF;
        else if (wake_event) nxt_mode = pss_pkg::PSS_RESTORE;
      end
      pss_pkg::PSS_RESTORE: nxt_mode = pss_pkg::PSS_ACTIVE;
      default: begin
        if (any_on) nxt_mode = pss_pkg::PSS_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) mode_ff <= pss_pkg::PSS_OFF;
    else mode_ff <= nxt_mode;
  end

  // Wake timer runs on the low-power clock while asleep
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wake_cnt_ff <= pss_pkg::WAKE_ONE;
    end else if (mode_ff == pss_pkg::PSS_ACTIVE ||
                 mode_ff == pss_pkg::PSS_OFF) begin
      wake_cnt_ff <= (wake_ticks == pss_pkg::WAKE_ZERO) ?
        pss_pkg::WAKE_ONE : wake_ticks;
    end else if (lpo_tick && wake_cnt_ff != pss_pkg::WAKE_ZERO) begin
      wake_cnt_ff <= wake_cnt_ff - pss_pkg::WAKE_ONE;
    end
  end

  // Retention memory lives in the always-on domain
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      retain_ff <= pss_pkg::STATE_RST;
      core_state_out <= pss_pkg::STATE_RST;
      retention_save <= 1'b0;
      retention_restore <= 1'b0;
    end else begin
      retention_save <= (mode_ff == pss_pkg::PSS_SAVE);
      retention_restore <= (mode_ff == pss_pkg::PSS_RESTORE);
      if (mode_ff == pss_pkg::PSS_SAVE) retain_ff <= core_state_in;
      if (mode_ff == pss_pkg::PSS_RESTORE) core_state_out <= retain_ff;
    end
  end

  // Demand per resource from mode and enables
  always_comb begin
    demand = '0;
    if (mode_ff != pss_pkg::PSS_OFF) begin
      demand[pss_pkg::RES_BUCK] = any_on;
      demand[pss_pkg::RES_CLIN] = any_on & baseband_demand;
      demand[pss_pkg::RES_LNLIN] = any_on & baseband_demand;
      demand[pss_pkg::RES_RADIO] = wl_on &
        (mode_ff == pss_pkg::PSS_ACTIVE);
      demand[pss_pkg::RES_PLL] = wl_on &
        (mode_ff == pss_pkg::PSS_ACTIVE);
      demand[pss_pkg::RES_CORE] = wl_on &
        (mode_ff != pss_pkg::PSS_DEEP);
    end
  end

  // One timed slot per resource
  for (genvar g = 0; g < N; g++) begin : g_res
    pss_res_if res ();
    pss_res_slot u_slot (
      .ref_clk(ref_clk),
      .reset(reset),
      .res(res.slot)
    );
    logic [N-1:0] users;
    for (genvar k = 0; k < N; k++) begin : g_users
      localparam logic [N-1:0] USES = pss_pkg::dep_mask(k);
      assign users[k] = USES[g];
    end
    assign res.tick = lpo_tick;
    assign res.request = demand[g];
    // A dependency that is already turning off does not count as enabled
    assign res.deps_ok = &(~pss_pkg::dep_mask(g) |
      (on_vec & ~pend_vec));
    assign res.no_dependents = ~|(users & (on_vec | pend_vec));
    assign res.time_on = time_on_ff[g];
    assign res.time_off = time_off_ff[g];
    assign on_vec[g] = res.resource_on_state;
    assign pend_vec[g] = res.resource_transition_pending;
  end

  // Outputs registered from resource state and mode
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      core_buck_regulator_en <= 1'b0;
      core_linear_regulator_en <= 1'b0;
      low_noise_linear_regulator_en <= 1'b0;
      always_on_low_power_regulator_en <= 1'b1;
      radio_power_en <= 1'b0;
      ref_clock_en <= 1'b0;
      core_power_en <= 1'b0;
      core_clock_en <= 1'b0;
      wireless_section_in_reset <= 1'b1;
      short_range_section_in_reset <= 1'b1;
      power_mode <= 3'(pss_pkg::PSS_OFF);
    end else begin
      core_buck_regulator_en <= on_vec[pss_pkg::RES_BUCK];
      core_linear_regulator_en <= on_vec[pss_pkg::RES_CLIN];
      low_noise_linear_regulator_en <= on_vec[pss_pkg::RES_LNLIN];
      always_on_low_power_regulator_en <= 1'b1;
      radio_power_en <= on_vec[pss_pkg::RES_RADIO];
      ref_clock_en <= on_vec[pss_pkg::RES_PLL];
      core_power_en <= on_vec[pss_pkg::RES_CORE];
      // Gate the core clock whenever nothing needs it
      core_clock_en <= on_vec[pss_pkg::RES_PLL] & clock_needed &
        (mode_ff == pss_pkg::PSS_ACTIVE);
      wireless_section_in_reset <= ~wl_sync_ff[1];
      short_range_section_in_reset <= ~sr_sync_ff[1];
      power_mode <= 3'(mode_ff);
    end
  end

  AST_OFF_WHEN_BOTH_LOW: assert property (
    @(posedge ref_clk) disable iff (reset)
    (!any_on && mode_ff == pss_pkg::PSS_ACTIVE)
      |=> mode_ff == pss_pkg::PSS_OFF)
    else $error("active mode kept with both enables low");

  AST_WL_RESET: assert property (
    @(posedge ref_clk) disable iff (reset)
    !wl_sync_ff[1] |=> wireless_section_in_reset)
    else $error("wireless section released while enable low");

  AST_SAVE_BEFORE_DEEP: assert property (
    @(posedge ref_clk) disable iff (reset)
    (mode_ff == pss_pkg::PSS_DEEP && $past(mode_ff) != pss_pkg::PSS_DEEP)
      |-> $past(mode_ff) == pss_pkg::PSS_SAVE)
    else $error("deep sleep entered without saving state");

  AST_RESTORE_DATA: assert property (
    @(posedge ref_clk) disable iff (reset)
    (mode_ff == pss_pkg::PSS_RESTORE)
      |=> retention_restore && core_state_out == retain_ff)
    else $error("retained state not restored on wake");
endmodule : pss_sequencer

/* File: pss_host_model.sv */
module pss_host_model #(
  parameter int LPO_HALF = 10
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic wl_cmd,
  input wire logic sr_cmd,
  output logic wireless_section_enable,
  output logic short_range_section_enable,
  output logic low_power_oscillator
);
  timeunit 1ns;
  timeprecision 100ps;
  logic wl_ff;
  logic sr_ff;
  logic lpo_ff;
  int cnt_ff;
  // Host pins move just after an edge, as board logic would
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wl_ff <= 1'h0;
      sr_ff <= 1'h0;
    end else begin
      wl_ff <= wl_cmd;
      sr_ff <= sr_cmd;
    end
  end
  // Oscillator runs free, scaled down so a tick is short
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cnt_ff <= 0;
      lpo_ff <= 1'h0;
    end else if (cnt_ff == LPO_HALF - 1) begin
      cnt_ff <= 0;
      lpo_ff <= !lpo_ff;
    end else begin
      cnt_ff <= cnt_ff + 1;
    end
  end
  assign wireless_section_enable = wl_ff;
  assign short_range_section_enable = sr_ff;
  assign low_power_oscillator = lpo_ff;
endmodule : pss_host_model

/* File: tb_pss_sequencer.sv */
module tb_pss_sequencer;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TICK = 20;
  typedef struct packed {
    logic wl; logic sr; logic [2:0] regs;
    logic wl_rst; logic sr_rst; logic [2:0] mode;
  } pss_row_t;
  pss_row_t rows [5] = '{'{1'h1, 1'h0, 3'h7, 1'h0, 1'h1, 3'h0},
    '{1'h0, 1'h1, 3'h7, 1'h1, 1'h0, 3'h0},
    '{1'h1, 1'h1, 3'h7, 1'h0, 1'h0, 3'h0},
    '{1'h0, 1'h0, 3'h0, 1'h1, 1'h1, 3'h5},
    '{1'h1, 1'h0, 3'h7, 1'h0, 1'h1, 3'h0}};
  logic ref_clk, reset, wl_cmd, sr_cmd, wireless_section_enable;
  logic short_range_section_enable, low_power_oscillator, ext_wake_irq;
  logic usb_resume, baseband_demand, clock_needed, doze_request;
  logic deep_sleep_request, prog_we, core_buck_regulator_en;
  logic core_linear_regulator_en, low_noise_linear_regulator_en;
  logic always_on_low_power_regulator_en, radio_power_en, ref_clock_en;
  logic core_power_en, core_clock_en, wireless_section_in_reset;
  logic short_range_section_in_reset, retention_save, retention_restore;
  logic [15:0] wake_ticks;
  logic [31:0] core_state_in, core_state_out;
  logic [2:0] prog_index, power_mode;
  logic [7:0] prog_time_on, prog_time_off;
  int failures = 0;
  int total_checks = 0;
  logic saw;
  logic [31:0] word;

  pss_host_model #(.LPO_HALF(TICK / 2)) host (.ref_clk, .reset, .wl_cmd,
    .sr_cmd, .wireless_section_enable, .short_range_section_enable,
    .low_power_oscillator);
  pss_sequencer dut (.ref_clk, .reset, .wireless_section_enable,
    .short_range_section_enable, .low_power_oscillator, .ext_wake_irq,
    .usb_resume, .baseband_demand, .clock_needed, .doze_request,
    .deep_sleep_request, .wake_ticks, .core_state_in, .prog_we, .prog_index,
    .prog_time_on, .prog_time_off, .core_buck_regulator_en,
    .core_linear_regulator_en, .low_noise_linear_regulator_en,
    .always_on_low_power_regulator_en, .radio_power_en, .ref_clock_en,
    .core_power_en, .core_clock_en, .wireless_section_in_reset,
    .short_range_section_in_reset, .retention_save, .retention_restore,
    .core_state_out, .power_mode);

  // Free-running system clock
  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = !ref_clk;
  end

  task automatic check(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      failures++;
    end
  endtask : check

  task automatic wrap_up();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up

  task automatic ticks(input int n);
    repeat (n * TICK) @(posedge ref_clk);
    #1;
  endtask : ticks

  // Bounded wait for a mode; notes pulses seen on the way
  task automatic wait_mode(input logic [2:0] m, input int lim);
    saw = 1'h0;
    for (int j = 0; j < lim && power_mode !== m; j++) begin
      @(posedge ref_clk);
      #1;
      if (retention_save === 1'h1 && power_mode === 3'h2) saw = 1'h1;
      if (retention_restore === 1'h1) saw = 1'h1;
    end
    if (power_mode !== m) begin
      $display("ERROR mode_wait expected %h seen %h", m, power_mode);
      failures++;
      wrap_up();
    end
  endtask : wait_mode

  // Core linear, radio and reference clock never on while what they lean on is off
  always @(posedge ref_clk) begin
    if (!reset && ((core_linear_regulator_en && !core_buck_regulator_en)
        || (radio_power_en && !low_noise_linear_regulator_en)
        || (ref_clock_en && !core_linear_regulator_en))) begin
      $display("ERROR dependency expected 0 seen 1");
      failures++;
    end
  end

  initial begin
    reset = 1'h1;
    {wl_cmd, sr_cmd, ext_wake_irq, usb_resume, doze_request} = 5'h00;
    {deep_sleep_request, prog_we, prog_index} = 5'h00;
    {baseband_demand, clock_needed} = 2'h3;
    {prog_time_on, prog_time_off, wake_ticks} = 32'h0;
    core_state_in = 32'h0;
    repeat (12) @(posedge ref_clk);
    #1;
    check("rst_buck", 32'h0, core_buck_regulator_en);
    check("rst_aon", 32'h1, always_on_low_power_regulator_en);
    check("rst_wl", 32'h1, wireless_section_in_reset);
    check("rst_mode", 32'h5, power_mode);
    @(posedge ref_clk);
    reset <= 1'h0;
    // Timing table; index 6 is out of range, core turns on instantly
    for (int i = 0; i < 7; i++) begin
      @(posedge ref_clk);
      prog_we <= 1'h1;
      prog_index <= i[2:0];
      prog_time_on <= (i == 5) ? 8'h00 : 8'h01;
      prog_time_off <= 8'h01;
    end
    @(posedge ref_clk);
    prog_we <= 1'h0;
    // Enable combinations, each left to settle
    foreach (rows[i]) begin
      @(posedge ref_clk);
      wl_cmd <= rows[i].wl;
      sr_cmd <= rows[i].sr;
      ticks(30);
      check("regs", rows[i].regs, {core_buck_regulator_en,
        core_linear_regulator_en, low_noise_linear_regulator_en});
      check("wl_rst", rows[i].wl_rst, wireless_section_in_reset);
      check("sr_rst", rows[i].sr_rst, short_range_section_in_reset);
      check("mode", rows[i].mode, power_mode);
    end
    check("core_clk", 32'h1, core_clock_en);
    check("core_pwr", 32'h1, core_power_en);
    @(posedge ref_clk);
    clock_needed <= 1'h0;
    ticks(1);
    check("core_clk_gated", 32'h0, core_clock_en);
    // Short-range only: radio and clock leave, so idle baseband lets both
    // linear regulators drop while the buck stays
    clock_needed <= 1'h1;
    baseband_demand <= 1'h0;
    wl_cmd <= 1'h0;
    sr_cmd <= 1'h1;
    ticks(20);
    check("lin_off", 32'h0, {core_linear_regulator_en,
      low_noise_linear_regulator_en});
    check("buck_kept", 32'h1, core_buck_regulator_en);
    baseband_demand <= 1'h1;
    wl_cmd <= 1'h1;
    sr_cmd <= 1'h0;
    ticks(20);
    check("lin_on", 32'h3, {core_linear_regulator_en,
      low_noise_linear_regulator_en});
    // Doze, left again by the sequencer's own timer
    @(posedge ref_clk);
    wake_ticks <= 16'h0004;
    doze_request <= 1'h1;
    wait_mode(3'h1, 10);
    doze_request <= 1'h0;
    // Resources drop only on ticks; the wake timer needs four
    ticks(2);
    repeat (10) @(posedge ref_clk);
    #1;
    check("doze_mode", 32'h1, power_mode);
    check("doze_rf", 32'h0, {radio_power_en, ref_clock_en,
      core_clock_en});
    wait_mode(3'h0, 20 * TICK);
    // Deep sleep once per wake source: timer, interrupt, USB resume
    for (int s = 0; s < 3; s++) begin
      ticks(20);
      word = 32'hA5C3_0F1E ^ s;
      wake_ticks <= (s == 0) ? 16'h0003 : 16'hFFFF;
      core_state_in <= word;
      deep_sleep_request <= 1'h1;
      wait_mode(3'h3, 20);
      check("save_pulse", 32'h1, saw);
      deep_sleep_request <= 1'h0;
      core_state_in <= 32'h0;
      if (s > 0) begin
        ticks(3);
        check("still_deep", 32'h3, power_mode);
        check("deep_core", 32'h0, core_power_en);
      end
      ext_wake_irq <= (s == 1);
      usb_resume <= (s == 2);
      wait_mode(3'h0, 10 * TICK);
      check("restore_pulse", 32'h1, saw);
      check("state", word, core_state_out);
      ext_wake_irq <= 1'h0;
      usb_resume <= 1'h0;
    end
    // Power-down ignores wake pins; only the host enables bring it back
    wl_cmd <= 1'h0;
    ticks(30);
    ext_wake_irq <= 1'h1;
    usb_resume <= 1'h1;
    ticks(10);
    check("off_mode", 32'h5, power_mode);
    check("off_regs", 32'h0, {core_buck_regulator_en,
      core_linear_regulator_en, low_noise_linear_regulator_en});
    check("off_aon", 32'h1, always_on_low_power_regulator_en);
    wrap_up();
  end
endmodule : tb_pss_sequencer
